// >>> hw/adc_seq_params.svh
// Constants shared by the sample sequencer design files
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define ADC_RES_W 10
`define RESULT_W 32
`define SEQ_N 4
`define SEQ0_DEPTH 8
`define SEQ12_DEPTH 4
`define SEQ3_DEPTH 1
`define NIBBLE_W 4
`define CTL_DIFF 0
`define CTL_END 1
`define CTL_IE 2
`define CTL_TS 3
`define TRIG_SW 2'h0
`define TRIG_TIMER 2'h1
`define TRIG_COMP 2'h2
`define TRIG_GPIO 2'h3
`define AVG_MAX_SHIFT 3'h6
`define SUM_W 16
`define PTR_W 3
`endif

// >>> hw/adc_seq_pkg.sv
// Types shared by the sample sequencer design files
package adc_seq_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_WAIT = 2'b10,
		ST_AVG = 2'b11
	} seq_state_e;

	typedef struct packed {
		logic [3:0] input_sel;
		logic temp_sel;
		logic diff;
	} conv_req_s;

	typedef struct packed {
		logic [2:0] head;
		logic [2:0] tail;
		logic full;
		logic empty;
	} queue_status_s;

	typedef struct packed {
		seq_state_e state;
		logic [1:0] cur;
		logic [2:0] step;
		logic [3:0] pending;
		logic [3:0] ovf;
		logic [3:0] unf;
		logic [3:0] raw;
		logic conv_start;
		conv_req_s req;
		logic [2:0] gsync;
		logic glevel;
	} ctrl_state_s;
endpackage : adc_seq_pkg

// >>> hw/result_queue.sv
// Circular result queue with pop port, pointer status and error pulses
`include "adc_seq_params.svh"
module result_queue #(
	parameter int DEPTH = `SEQ0_DEPTH
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Fill side
	input wire logic push,
	input wire logic [`ADC_RES_W-1:0] push_data,
	// Drain side
	input wire logic pop,
	output logic [`RESULT_W-1:0] pop_data,
	// Status
	output adc_seq_pkg::queue_status_s status,
	output logic overflow,
	output logic underflow
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][`ADC_RES_W-1:0] mem;
		logic [PW-1:0] head;
		logic [PW-1:0] tail;
		logic [PW:0] count;
		logic [`RESULT_W-1:0] rdata;
		logic ovf;
		logic unf;
	} queue_state_s;

	queue_state_s s, n;
	logic full, empty, do_pop, do_push;

	assign full = (s.count == (PW + 1)'(DEPTH));
	assign empty = (s.count == '0);
	assign do_pop = pop && !empty;
	// A pop in the same cycle frees a slot, so a full queue still takes the push
	assign do_push = push && (!full || pop);

	always_comb begin
		n = s;
		n.ovf = push && !do_push; // R18
		n.unf = pop && empty; // R18
		if (do_pop) begin
			n.rdata = `RESULT_W'(s.mem[s.tail]); // R3 R10
			n.tail = (s.tail == LAST) ? '0 : s.tail + 1'b1;
		end
		if (do_push) begin
			n.mem[s.head] = push_data;
			n.head = (s.head == LAST) ? '0 : s.head + 1'b1;
		end
		n.count = s.count + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign pop_data = s.rdata;
	assign status = '{head: `PTR_W'(s.head), tail: `PTR_W'(s.tail), full: full, empty: empty}; // R11
	assign overflow = s.ovf;
	assign underflow = s.unf;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// A push landing with the refused pop still fills the empty queue
	chk_empty_pop_stable: assert property (pop && empty |=> $stable(s.tail) && s.count == (PW + 1)'($past(push))) // R18
		else $error("Pop of empty queue moved the read pointer");
	chk_full_push_drop: assert property (push && full && !pop |=> overflow && s.count == $past(s.count)) // R18
		else $error("Push into full queue was not dropped and flagged");
endmodule : result_queue

// >>> hw/avg_unit.sv
// Accumulate a power-of-two number of conversions into one result
`include "adc_seq_params.svh"
module avg_unit (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic [2:0] shift,
	// Samples in
	input wire logic sample_valid,
	input wire logic [`ADC_RES_W-1:0] sample,
	// Result out
	output logic avg_valid,
	output logic [`ADC_RES_W-1:0] avg
);
	typedef struct packed {
		logic [`SUM_W-1:0] sum;
		logic [6:0] cnt;
		logic valid;
		logic [`ADC_RES_W-1:0] avg;
	} avg_state_s;

	avg_state_s s, n;
	logic [2:0] sh;
	logic [`SUM_W-1:0] nsum;
	logic [6:0] total;

	// Shift codes above the limit behave as the deepest average
	assign sh = (shift > `AVG_MAX_SHIFT) ? `AVG_MAX_SHIFT : shift;
	assign nsum = s.sum + `SUM_W'(sample);
	assign total = 7'(7'h01 << sh);

	always_comb begin
		n = s;
		n.valid = 1'b0;
		if (clear) begin
			n.sum = '0;
			n.cnt = '0;
		end else if (sample_valid) begin
			if (s.cnt + 7'h01 == total) begin
				n.avg = `ADC_RES_W'(nsum >> sh); // R14
				n.valid = 1'b1;
				n.sum = '0;
				n.cnt = '0;
			end else begin
				n.sum = nsum;
				n.cnt = s.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign avg_valid = s.valid;
	assign avg = s.avg;
endmodule : avg_unit

// >>> hw/adc_sample_sequencer.sv
// Sample sequencer control: triggers, arbitration, step walk, result queues and status
//
// Functional notes
// R1 - Ten-bit results, eight inputs plus temperature sensor
// R2 - Four sequencers: eight, four, four, one steps
// R3 - Queue words are 32 bits, result low
// R4 - Each step has input and control nibbles
// R5 - Triggered steps convert back to back
// R6 - Sequencer runs only while enable bit set; a cleared bit still lets the running step finish
// R7 - Same input may appear in several steps
// R8 - Interrupt-enabled steps raise sequencer interrupt
// R9 - End bit finishes sequence, later steps skipped
// R10 - Each pop returns and removes oldest entry
// R11 - Head, tail, full and empty readable
// R12 - Separate overflow and underflow status per sequencer
// R13 - Software, timer, comparator and pin triggers
// R14 - Averaging of up to 64 conversions
// R15 - Pending triggers served by priority, zero highest
// R16 - Software keeps active priorities distinct
// R17 - Masked status is raw AND mask, write-one clears
// R18 - Full push drops result; empty pop flags underflow
// R19 - Error flags sticky until write-one clear
`include "adc_seq_params.svh"
module adc_sample_sequencer #(
	parameter int SEQ0_DEPTH = `SEQ0_DEPTH,
	parameter int SEQ12_DEPTH = `SEQ12_DEPTH,
	parameter int SEQ3_DEPTH = `SEQ3_DEPTH
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Sequence configuration
	input wire logic [`SEQ_N-1:0] sequencer_active,
	input wire logic [`SEQ_N-1:0][31:0] step_input_select,
	input wire logic [`SEQ_N-1:0][31:0] step_control,
	input wire logic [7:0] sequencer_priority,
	input wire logic [7:0] trigger_select,
	input wire logic [2:0] average_shift,
	// Trigger sources
	input wire logic [`SEQ_N-1:0] sw_initiate,
	input wire logic [`SEQ_N-1:0] trig_timer,
	input wire logic [`SEQ_N-1:0] trig_comparator,
	input wire logic trig_gpio,
	// Converter core
	output logic conv_start,
	output adc_seq_pkg::conv_req_s conv_req,
	input wire logic conv_done,
	input wire logic [`ADC_RES_W-1:0] conv_data,
	// Result queues
	input wire logic [`SEQ_N-1:0] result_pop,
	output logic [`SEQ_N-1:0][`RESULT_W-1:0] result_pop_port,
	output adc_seq_pkg::queue_status_s [`SEQ_N-1:0] result_queue_status,
	// Error status
	output logic [`SEQ_N-1:0] queue_overflow_status,
	input wire logic [`SEQ_N-1:0] overflow_clear,
	output logic [`SEQ_N-1:0] queue_underflow_status,
	input wire logic [`SEQ_N-1:0] underflow_clear,
	// Interrupt status
	input wire logic [`SEQ_N-1:0] irq_mask,
	input wire logic [`SEQ_N-1:0] irq_status_clear,
	output logic [`SEQ_N-1:0] irq_raw_status,
	output logic [`SEQ_N-1:0] irq_masked,
	output logic busy
);
	adc_seq_pkg::ctrl_state_s s, n;
	logic [`SEQ_N-1:0] req, hit, take_mask, irq_set, push, fifo_ovf, fifo_unf;
	logic found, last, step_done, gpio_event, avg_valid;
	logic [1:0] win;
	logic [3:0] sel, ctl;
	logic [`ADC_RES_W-1:0] avg;

	function automatic logic [2:0] last_of(input logic [1:0] q);
		case (q)
			2'h0: last_of = 3'(SEQ0_DEPTH - 1);
			2'h3: last_of = 3'(SEQ3_DEPTH - 1);
			default: last_of = 3'(SEQ12_DEPTH - 1);
		endcase
	endfunction : last_of

	// ----------------------------------------------------------------
	// Step decode and pin trigger
	// ----------------------------------------------------------------
	assign sel = step_input_select[s.cur][{s.step, 2'b00} +: `NIBBLE_W]; // R4 R7
	assign ctl = step_control[s.cur][{s.step, 2'b00} +: `NIBBLE_W]; // R4
	assign step_done = (s.state == adc_seq_pkg::ST_AVG) && avg_valid;
	// Disabling a running sequencer ends it at the next step boundary
	assign last = ctl[`CTL_END] || (s.step == last_of(s.cur)) || !sequencer_active[s.cur]; // R2 R6 R9
	assign irq_set = (step_done && ctl[`CTL_IE]) ? 4'(4'h1 << s.cur) : 4'h0; // R8
	assign push = step_done ? 4'(4'h1 << s.cur) : 4'h0;
	// Pin edge counts once the second and third stages agree
	assign gpio_event = (s.gsync[2] == s.gsync[1]) && s.gsync[2] && !s.glevel; // R13
	assign req = s.pending & sequencer_active; // R6

	// ----------------------------------------------------------------
	// Per-sequencer trigger select and result queue
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < `SEQ_N; g++) begin : gen_seq
			localparam int DEPTH = (g == 0) ? SEQ0_DEPTH : (g == 3) ? SEQ3_DEPTH : SEQ12_DEPTH;
			logic [1:0] tsel;
			assign tsel = trigger_select[2 * g +: 2];
			assign hit[g] = sequencer_active[g] && ( // R13
				(tsel == `TRIG_SW) ? sw_initiate[g] :
				(tsel == `TRIG_TIMER) ? trig_timer[g] :
				(tsel == `TRIG_COMP) ? trig_comparator[g] : gpio_event);

			result_queue #(.DEPTH(DEPTH)) u_queue ( // R2 R10
				.mclk(mclk),
				.rst_n(rst_n),
				.push(push[g]),
				.push_data(avg),
				.pop(result_pop[g]),
				.pop_data(result_pop_port[g]),
				.status(result_queue_status[g]),
				.overflow(fifo_ovf[g]),
				.underflow(fifo_unf[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Averaging
	// ----------------------------------------------------------------
	avg_unit u_avg ( // R14
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(s.state == adc_seq_pkg::ST_IDLE),
		.shift(average_shift),
		.sample_valid(s.state == adc_seq_pkg::ST_WAIT && conv_done),
		.sample(conv_data),
		.avg_valid(avg_valid),
		.avg(avg)
	);

	// ----------------------------------------------------------------
	// Priority arbiter
	// ----------------------------------------------------------------
	// Equal priorities fall back to the lower index; software must avoid them
	always_comb begin
		logic [1:0] best;
		best = 2'h3;
		found = 1'b0;
		win = 2'h0;
		for (int i = 0; i < `SEQ_N; i++) begin
			if (req[i] && (!found || sequencer_priority[2 * i +: 2] < best)) begin // R15 R16
				found = 1'b1;
				win = 2'(i);
				best = sequencer_priority[2 * i +: 2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer control
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		take_mask = 4'h0;
		n.conv_start = 1'b0;
		n.gsync = {s.gsync[1:0], trig_gpio};
		if (s.gsync[2] == s.gsync[1]) begin
			n.glevel = s.gsync[2];
		end
		// Hardware sets win over a simultaneous clear
		n.ovf = (s.ovf & ~overflow_clear) | fifo_ovf; // R12 R19
		n.unf = (s.unf & ~underflow_clear) | fifo_unf; // R12 R19
		n.raw = (s.raw & ~(irq_status_clear & irq_mask)) | irq_set; // R17
		case (s.state)
			adc_seq_pkg::ST_IDLE: begin
				if (found) begin
					n.cur = win; // R15
					n.step = 3'h0;
					n.state = adc_seq_pkg::ST_START;
					take_mask = 4'(4'h1 << win);
				end
			end
			adc_seq_pkg::ST_START: begin
				n.conv_start = 1'b1;
				n.req = '{input_sel: sel, temp_sel: ctl[`CTL_TS], diff: ctl[`CTL_DIFF]}; // R1 R4
				n.state = adc_seq_pkg::ST_WAIT;
			end
			adc_seq_pkg::ST_WAIT: begin
				if (conv_done) begin
					n.state = adc_seq_pkg::ST_AVG;
				end
			end
			adc_seq_pkg::ST_AVG: begin
				if (!avg_valid) begin
					n.state = adc_seq_pkg::ST_START; // R14
				end else if (last) begin
					n.state = adc_seq_pkg::ST_IDLE; // R9
				end else begin
					n.step = s.step + 3'h1; // R5
					n.state = adc_seq_pkg::ST_START;
				end
			end
			default: begin
				n.state = adc_seq_pkg::ST_IDLE;
			end
		endcase
		// A trigger landing as its sequence is taken stays pending for a rerun
		n.pending = (s.pending & sequencer_active & ~take_mask) | hit; // R6 R13
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign conv_start = s.conv_start;
	assign conv_req = s.req;
	assign queue_overflow_status = s.ovf;
	assign queue_underflow_status = s.unf;
	assign irq_raw_status = s.raw;
	assign irq_masked = s.raw & irq_mask; // R17
	assign busy = (s.state != adc_seq_pkg::ST_IDLE);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_step_more;
		step_done && !last;
	endsequence

	sequence s_next_conv;
		s.state == adc_seq_pkg::ST_START ##1 conv_start;
	endsequence

	logic better;
	always_comb begin
		better = 1'b0;
		for (int j = 0; j < `SEQ_N; j++) begin
			if (req[j] && sequencer_priority[2 * j +: 2] < sequencer_priority[2 * win +: 2]) begin
				better = 1'b1;
			end
		end
	end

	chk_conv_one_shot: assert property (conv_start |=> !conv_start ##1 !conv_start) // R5
		else $error("Conversion start lasted more than one cycle");
	chk_back_to_back: assert property (s_step_more |=> s_next_conv) // R5
		else $error("Next step did not start at once");
	chk_end_stops: assert property (step_done && ctl[`CTL_END] |=> !busy ##1 !conv_start) // R9
		else $error("Sequence ran past its end step");
	chk_step_irq: assert property (step_done && ctl[`CTL_IE] |=> irq_raw_status[$past(s.cur)]) // R8
		else $error("Step interrupt not raised");
	chk_prio_pick: assert property (!busy && found |-> !better ##1 s.cur == $past(win) && busy) // R15
		else $error("Arbiter skipped a higher priority sequencer");
	chk_idle_enable: assert property (!busy && !found |=> !busy) // R6
		else $error("Sequencer started without an enabled request");
	chk_irq_clear: assert property (irq_raw_status[0] && irq_status_clear[0] && irq_mask[0] && !irq_set[0]
		|=> !irq_raw_status[0]) // R17
		else $error("Write-one clear of masked status failed");
	chk_ovf_sticky: assert property ((queue_overflow_status & ~overflow_clear) != 4'h0
		|=> (queue_overflow_status & $past(queue_overflow_status & ~overflow_clear))
		== $past(queue_overflow_status & ~overflow_clear)) // R19
		else $error("Overflow flag dropped without a clear");
	chk_ovf_on_full: assert property (step_done && result_queue_status[s.cur].full && !result_pop[s.cur]
		|-> ##2 queue_overflow_status[$past(s.cur, 2)]) // R18
		else $error("Push into full queue not flagged");
	chk_unf_on_empty: assert property (result_pop[0] && result_queue_status[0].empty
		|-> ##2 queue_underflow_status[0]) // R12
		else $error("Pop of empty queue not flagged");

	// ----------------------------------------------------------------
	// Checks on requests, triggers and sticky flags
	// ----------------------------------------------------------------
	sequence s_issue;
		s.state == adc_seq_pkg::ST_START;
	endsequence

	sequence s_pin_rise;
		gpio_event;
	endsequence

	chk_req_nibbles: assert property (s_issue |=> conv_start && conv_req.input_sel == $past(sel) // R4
		&& conv_req.temp_sel == $past(ctl[`CTL_TS]) && conv_req.diff == $past(ctl[`CTL_DIFF]))
		else $error("Conversion request does not match the step nibbles");
	chk_pin_once: assert property (s_pin_rise |=> !gpio_event) // R13
		else $error("Pin edge counted more than once");
	chk_hit_pending: assert property (hit[1] |=> s.pending[1]) // R13
		else $error("Trigger was not kept pending");
	chk_inactive_drop: assert property (!sequencer_active[0] |=> !s.pending[0]) // R6
		else $error("Disabled sequencer kept a pending trigger");
	chk_take_clears: assert property (s.state == adc_seq_pkg::ST_IDLE && found && !hit[win] // R15
		|=> !s.pending[$past(win)])
		else $error("Chosen sequencer stayed pending");
	chk_idle_quiet: assert property (!busy |-> !conv_start) // R6
		else $error("Conversion started while idle");
	chk_wait_hold: assert property (s.state == adc_seq_pkg::ST_WAIT && !conv_done |=> s.state == adc_seq_pkg::ST_WAIT) // R5
		else $error("Step left the wait state without a result");
	chk_ovf_set_wins: assert property (fifo_ovf[3] |=> queue_overflow_status[3]) // R12 R19
		else $error("Overflow event lost against a clear");
	chk_unf_sticky: assert property (queue_underflow_status[0] && !underflow_clear[0] // R19
		|=> queue_underflow_status[0])
		else $error("Underflow flag dropped without a clear");
endmodule : adc_sample_sequencer

// >>> dv/conv_core_model.sv
// Behavioural converter core answering each conversion start
module conv_core_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Request from the sequencer
	input wire logic conv_start,
	input wire adc_seq_pkg::conv_req_s conv_req,
	input wire logic [1:0] lat,
	input wire logic [3:0] tag,
	// Result back
	output logic conv_done,
	output logic [9:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt;
	logic [9:0] val;
	// Data toggles outside the done pulse so a stale sample never looks valid
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 2'h0;
			val <= 10'h000;
			conv_done <= 1'b0;
			conv_data <= 10'h000;
		end else begin
			conv_done <= (cnt == 2'h1);
			conv_data <= (cnt == 2'h1) ? val : ~conv_data;
			if (conv_start) begin
				cnt <= (lat == 2'h0) ? 2'h1 : lat;
				val <= {tag, conv_req};
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule : conv_core_model

// >>> dv/adc_sample_sequencer_bench.sv
// Self-checking bench for the sample sequencer
module adc_sample_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, trig_gpio, conv_start, conv_done, busy;
	logic [3:0] sequencer_active, sw_initiate, trig_timer, trig_comparator, result_pop, overflow_clear;
	logic [3:0] underflow_clear, irq_mask, irq_status_clear, queue_overflow_status, queue_underflow_status;
	logic [3:0] irq_raw_status, irq_masked, exp_irq, tag;
	logic [3:0] popped = 4'h0;
	logic [3:0][31:0] step_input_select, step_control, result_pop_port;
	logic [7:0] sequencer_priority, trigger_select;
	logic [2:0] average_shift;
	logic [1:0] lat;
	logic [9:0] conv_data;
	adc_seq_pkg::conv_req_s conv_req;
	adc_seq_pkg::queue_status_s [3:0] result_queue_status;
	adc_seq_pkg::conv_req_s exp_req[$];
	logic [31:0] exp_word[$];
	int err_count = 0;
	int n_compared = 0;

	adc_sample_sequencer i_adc_sample_sequencer (.mclk, .rst_n, .sequencer_active, .step_input_select,
		.step_control, .sequencer_priority, .trigger_select, .average_shift, .sw_initiate, .trig_timer,
		.trig_comparator, .trig_gpio, .conv_start, .conv_req, .conv_done, .conv_data, .result_pop,
		.result_pop_port, .result_queue_status, .queue_overflow_status, .overflow_clear,
		.queue_underflow_status, .underflow_clear, .irq_mask, .irq_status_clear, .irq_raw_status,
		.irq_masked, .busy);
	conv_core_model i_conv_core_model (.mclk, .rst_n, .conv_start, .conv_req, .lat, .tag, .conv_done,
		.conv_data);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic bad(input string m);
		err_count++;
		$display("BAD %0t %s", $time, m);
	endtask : bad

	task automatic cmp_req(input adc_seq_pkg::conv_req_s g, input adc_seq_pkg::conv_req_s e);
		n_compared++;
		if (g !== e) bad("conversion request");
	endtask : cmp_req

	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) bad("result word");
	endtask : cmp_word

	task automatic cmp_bits(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) bad("status bits");
	endtask : cmp_bits

	task automatic complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// A start or a word with no note counts as a mismatch
	always @(posedge mclk) begin
		if (conv_start === 1'b1) begin
			if (exp_req.size() == 0) bad("conversion start with no note");
			else cmp_req(conv_req, exp_req.pop_front());
		end
		for (int i = 0; i < 4; i++) begin
			if (popped[i] && exp_word.size() == 0) bad("result word with no note");
			else if (popped[i]) cmp_word(result_pop_port[i], exp_word.pop_front());
			popped[i] <= result_pop[i] & ~result_queue_status[i].empty;
		end
	end

	// ----------------------------------------
	// Stimulus tasks
	// ----------------------------------------
	task automatic cfg(input int s, input int n, input int src, input logic [2:0] av, input bit note);
		logic [31:0] vi;
		logic [31:0] vc;
		logic [3:0] c;
		for (int k = 0; k < 8; k++) begin
			vi[4*k+:4] = (k == 1) ? vi[3:0] : 4'($urandom % 8);
			c = 4'($urandom);
			c[1] = (k == n - 1);
			vc[4*k+:4] = c;
			if (k < n) begin
				exp_irq[s] = exp_irq[s] | c[2];
				for (int r = 0; r < (1 << av); r++)
					exp_req.push_back({vi[4*k+:4], c[3], c[0]});
				if (note)
					exp_word.push_back({22'h0, tag, vi[4*k+:4], c[3], c[0]});
			end
		end
		step_input_select[s] <= vi;
		step_control[s] <= vc;
		average_shift <= av;
		trigger_select[2*s+:2] <= 2'(src);
		sequencer_active[s] <= 1'b1;
		lat <= 2'(1 + $urandom % 3);
		@(posedge mclk);
	endtask : cfg

	task automatic fire(input logic [3:0] m, input int src);
		case (src)
			0: sw_initiate <= m;
			1: trig_timer <= m;
			2: trig_comparator <= m;
			default: trig_gpio <= 1'b1;
		endcase
		@(posedge mclk);
		sw_initiate <= 4'h0;
		trig_timer <= 4'h0;
		trig_comparator <= 4'h0;
		repeat (6) @(posedge mclk);
		trig_gpio <= 1'b0;
		for (int t = 0; t < 3000 && (exp_req.size() != 0 || busy !== 1'b0); t++) @(posedge mclk);
		if (exp_req.size() != 0 || busy !== 1'b0) bad("sequence did not finish");
		repeat (4) @(posedge mclk);
	endtask : fire

	task automatic drain(input int s, input int n);
		result_pop <= 4'(1 << s);
		repeat (n) @(posedge mclk);
		result_pop <= 4'h0;
		repeat (3) @(posedge mclk);
	endtask : drain

	task automatic clr(input logic [3:0] o, input logic [3:0] u, input logic [3:0] q);
		overflow_clear <= o;
		underflow_clear <= u;
		irq_status_clear <= q;
		@(posedge mclk);
		overflow_clear <= 4'h0;
		underflow_clear <= 4'h0;
		irq_status_clear <= 4'h0;
		@(posedge mclk);
	endtask : clr

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(97));
		{rst_n, trig_gpio, sequencer_active, sw_initiate, trig_timer, trig_comparator} = '0;
		{result_pop, overflow_clear, underflow_clear, irq_mask, irq_status_clear, exp_irq} = '0;
		{step_input_select, step_control, trigger_select, average_shift} = '0;
		sequencer_priority = 8'hE4;
		lat = 2'h1;
		tag = 4'($urandom);
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		cmp_bits(result_queue_status[0], 8'h01);
		// Timer start, end bit on the fifth step, then an empty pop
		cfg(0, 5, 1, 3'h0, 1'b1);
		fire(4'h1, 1);
		cmp_bits(result_queue_status[0], {3'h5, 3'h0, 2'h0});
		drain(0, 5);
		cmp_bits(result_queue_status[0], {3'h5, 3'h5, 2'h1});
		drain(0, 1);
		cmp_bits(8'(queue_underflow_status), 8'h01);
		cmp_bits(result_queue_status[0], {3'h5, 3'h5, 2'h1});
		clr(4'h0, 4'h1, 4'h1);
		cmp_bits(8'(queue_underflow_status), 8'h00);
		cmp_bits(8'(irq_raw_status), 8'(exp_irq));
		irq_mask <= 4'hF;
		repeat (2) @(posedge mclk);
		cmp_bits(8'(irq_masked), 8'(exp_irq));
		clr(4'h0, 4'h0, 4'h1);
		exp_irq[0] = 1'b0;
		cmp_bits(8'(irq_raw_status), 8'(exp_irq));
		// Simultaneous comparator triggers, sequencer two ranked first
		sequencer_active <= 4'h0;
		sequencer_priority <= 8'hC6;
		cfg(2, 3, 2, 3'h0, 1'b1);
		cfg(1, 4, 2, 3'h0, 1'b1);
		fire(4'h6, 2);
		cmp_bits(result_queue_status[1], {3'h0, 3'h0, 2'h2});
		drain(2, 3);
		cmp_bits(result_queue_status[2], {3'h3, 3'h3, 2'h1});
		drain(1, 4);
		// Pin-started single-entry queue overflows on its second run
		sequencer_active <= 4'h0;
		cfg(3, 1, 3, 3'h0, 1'b1);
		fire(4'h8, 3);
		cfg(3, 1, 3, 3'h0, 1'b0);
		fire(4'h8, 3);
		cmp_bits(8'(queue_overflow_status), 8'h08);
		cmp_bits(result_queue_status[3], 8'h02);
		drain(3, 1);
		clr(4'h8, 4'h0, 4'h0);
		cmp_bits(8'(queue_overflow_status), 8'h00);
		// Sixty-four conversions folded into one result
		cfg(3, 1, 0, 3'h6, 1'b1);
		fire(4'h8, 0);
		drain(3, 1);
		// Disabled sequencers ignore software initiate on all four, with only sequencer three set to the software source
		sequencer_active <= 4'h0;
		fire(4'hF, 0);
		cmp_bits(8'(exp_req.size() + exp_word.size()), 8'h00);
		cmp_bits(8'(busy), 8'h00);
		complete_run();
	end

	initial begin
		#1000000;
		bad("watchdog expired");
		complete_run();
	end
endmodule : adc_sample_sequencer_bench
